// ==== upb_top.sv ====
// APB register file with pull and boost control for the USB port
`timescale 1ns/100ps
`include "upb_cfg.svh"
module upb_top (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	// Boost comparators
	input wire logic vbus_at_target,
	input wire logic over_current,
	// Line terminations
	output logic dplus_pullup_on,
	output logic dplus_pulldown_on,
	output logic dminus_pulldown_on,
	// Boost drive
	output logic boost_pwm_out,
	output logic boost_pwm_oe,
	output logic vbus_target_select,
	output logic vbus_gen_on,
	output logic vbus_discharge_on,
	output logic usb_power_on
);
	upb_pkg::upb_reg_t ctrl_q, ctrl_d;
	upb_pkg::upb_reg_t otg_q, otg_d;
	upb_pkg::upb_reg_t pwr_q, pwr_d;
	upb_pkg::upb_reg_t perd_q, perd_d;
	upb_pkg::upb_reg_t pwmc_q, pwmc_d;
	upb_pkg::upb_word_t rdata_q, rdata_d;
	upb_pkg::upb_sel_e sel;
	upb_pkg::upb_reg_t status;
	upb_pkg::upb_reg_t wval;
	logic setup_ph, access_ph, wr_go;
	logic [7:0] pwm_count;

	// Address decode
	always_comb begin
		unique case (paddr)
			`UPB_OFS_USB_CTRL: sel = upb_pkg::UPB_SEL_USB_CTRL;
			`UPB_OFS_OTG_CTRL: sel = upb_pkg::UPB_SEL_OTG_CTRL;
			`UPB_OFS_PWR: sel = upb_pkg::UPB_SEL_PWR;
			`UPB_OFS_PER_DUTY: sel = upb_pkg::UPB_SEL_PER_DUTY;
			`UPB_OFS_PWM_CTRL: sel = upb_pkg::UPB_SEL_PWM_CTRL;
			`UPB_OFS_STATUS: sel = upb_pkg::UPB_SEL_STATUS;
			default: sel = upb_pkg::UPB_SEL_NONE;
		endcase
	end

	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable;
	assign wr_go = access_ph & pwrite;
	assign wval = pwdata[15:0];

	// Zero wait states, error on unmapped offsets
	assign pready = access_ph;
	assign pslverr = access_ph & (sel == upb_pkg::UPB_SEL_NONE);

	// Register writes
	always_comb begin
		ctrl_d = ctrl_q;
		otg_d = otg_q;
		pwr_d = pwr_q;
		perd_d = perd_q;
		pwmc_d = pwmc_q;
		if (wr_go) begin
			unique case (sel)
				upb_pkg::UPB_SEL_USB_CTRL: begin
					ctrl_d = wval & `UPB_MASK_USB_CTRL;
				end
				upb_pkg::UPB_SEL_OTG_CTRL: begin
					otg_d = wval & `UPB_MASK_OTG_CTRL;
				end
				upb_pkg::UPB_SEL_PWR: begin
					pwr_d = wval & `UPB_MASK_PWR;
				end
				upb_pkg::UPB_SEL_PER_DUTY: begin
					perd_d = wval & `UPB_MASK_PER_DUTY;
				end
				upb_pkg::UPB_SEL_PWM_CTRL: begin
					pwmc_d = wval & `UPB_MASK_PWM_CTRL;
				end
				upb_pkg::UPB_SEL_STATUS: begin
				end
				upb_pkg::UPB_SEL_NONE: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q <= `UPB_RST_REG;
			otg_q <= `UPB_RST_REG;
			pwr_q <= `UPB_RST_REG;
			perd_q <= `UPB_RST_REG;
			pwmc_q <= `UPB_RST_REG;
		end else begin
			ctrl_q <= ctrl_d;
			otg_q <= otg_d;
			pwr_q <= pwr_d;
			perd_q <= perd_d;
			pwmc_q <= pwmc_d;
		end
	end

	// Live state for software
	always_comb begin
		status = '0;
		status[0] = dplus_pullup_on;
		status[1] = dplus_pulldown_on;
		status[2] = dminus_pulldown_on;
		status[3] = boost_pwm_out;
		status[4] = boost_pwm_oe;
		status[5] = vbus_at_target;
		status[6] = over_current;
		status[15:8] = pwm_count;
	end

	// Read data captured in the setup cycle
	always_comb begin
		rdata_d = rdata_q;
		if (setup_ph) begin
			unique case (sel)
				upb_pkg::UPB_SEL_USB_CTRL: rdata_d = {16'h0000, ctrl_q};
				upb_pkg::UPB_SEL_OTG_CTRL: rdata_d = {16'h0000, otg_q};
				upb_pkg::UPB_SEL_PWR: rdata_d = {16'h0000, pwr_q};
				upb_pkg::UPB_SEL_PER_DUTY: rdata_d = {16'h0000, perd_q};
				upb_pkg::UPB_SEL_PWM_CTRL: rdata_d = {16'h0000, pwmc_q};
				upb_pkg::UPB_SEL_STATUS: rdata_d = {16'h0000, status};
				upb_pkg::UPB_SEL_NONE: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign prdata = rdata_q;

	// Terminations
	upb_pull_ctrl u_pull (
		.clk(clk),
		.srst(srst),
		.usb_module_enable(ctrl_q[`UPB_BIT_MOD_EN]),
		.host_role_enable(ctrl_q[`UPB_BIT_HOST_EN]),
		.otg_pull_override_enable(otg_q[`UPB_BIT_OVERRIDE]),
		.dplus_pullup_ctrl(otg_q[`UPB_BIT_DP_PU]),
		.dplus_pulldown_ctrl(otg_q[`UPB_BIT_DP_PD]),
		.dminus_pulldown_ctrl(otg_q[`UPB_BIT_DM_PD]),
		.dplus_pullup_on(dplus_pullup_on),
		.dplus_pulldown_on(dplus_pulldown_on),
		.dminus_pulldown_on(dminus_pulldown_on)
	);

	// Boost PWM
	upb_boost_pwm #(
		.W(8)
	) u_pwm (
		.clk(clk),
		.srst(srst),
		.period(perd_q[`UPB_PER_LSB +: 8]),
		.duty(perd_q[`UPB_DUTY_LSB +: 8]),
		.boost_counter_enable(pwmc_q[`UPB_BIT_CNT_EN]),
		.boost_pwm_enable(pwmc_q[`UPB_BIT_PWM_EN]),
		.boost_pwm_polarity(pwmc_q[`UPB_BIT_POL]),
		.vbus_at_target(vbus_at_target),
		.over_current(over_current),
		.pwm_out(boost_pwm_out),
		.pwm_oe(boost_pwm_oe),
		.count(pwm_count)
	);

	assign vbus_target_select = otg_q[`UPB_BIT_TARGET];
	assign vbus_gen_on = otg_q[`UPB_BIT_VBUS_GEN];
	assign vbus_discharge_on = otg_q[`UPB_BIT_DISCHG];
	assign usb_power_on = pwr_q[`UPB_BIT_PWR_ON];

	// Checks
	sequence s_ctrl_write;
		access_ph && pwrite && paddr == `UPB_OFS_USB_CTRL;
	endsequence

	sequence s_otg_write;
		access_ph && pwrite && paddr == `UPB_OFS_OTG_CTRL;
	endsequence

	sequence s_pwr_write;
		access_ph && pwrite && sel == upb_pkg::UPB_SEL_PWR;
	endsequence

	sequence s_pwmc_write;
		access_ph && pwrite && sel == upb_pkg::UPB_SEL_PWM_CTRL;
	endsequence

	sequence s_read_setup;
		setup_ph && !pwrite;
	endsequence

	sequence s_dead_write;
		access_ph && pwrite
		&& (sel == upb_pkg::UPB_SEL_NONE || sel == upb_pkg::UPB_SEL_STATUS);
	endsequence

	AST_DEV_PULLUP: assert property (@(posedge clk) disable iff (srst)
		s_ctrl_write ##0 !otg_q[`UPB_BIT_OVERRIDE] ##0 !pwdata[`UPB_BIT_HOST_EN]
		|-> ##2 dplus_pullup_on == $past(pwdata[`UPB_BIT_MOD_EN], 2))
		else $error("pull-up not following module enable");

	AST_OTG_PULLUP: assert property (@(posedge clk) disable iff (srst)
		s_otg_write ##0 pwdata[`UPB_BIT_OVERRIDE]
		|-> ##2 dplus_pullup_on == $past(pwdata[`UPB_BIT_DP_PU], 2))
		else $error("pull-up not following override bit");

	AST_HOST_PULLDOWN: assert property (@(posedge clk) disable iff (srst)
		s_ctrl_write ##0 pwdata[`UPB_BIT_HOST_EN] ##0 !otg_q[`UPB_BIT_OVERRIDE]
		|-> ##2 dplus_pulldown_on && dminus_pulldown_on && !dplus_pullup_on)
		else $error("host pull-downs missing");

	AST_OTG_PULLDOWN: assert property (@(posedge clk) disable iff (srst)
		s_otg_write ##0 pwdata[`UPB_BIT_OVERRIDE]
		|-> ##2 dplus_pulldown_on == $past(pwdata[`UPB_BIT_DP_PD], 2)
		&& dminus_pulldown_on == $past(pwdata[`UPB_BIT_DM_PD], 2))
		else $error("override pull-downs wrong");

	AST_PER_DUTY: assert property (@(posedge clk) disable iff (srst)
		access_ph && pwrite && paddr == `UPB_OFS_PER_DUTY
		|=> perd_q[7:0] == $past(pwdata[7:0]) && perd_q[15:8] == $past(pwdata[15:8]))
		else $error("period or duty field misplaced");

	AST_POL_IDLE: assert property (@(posedge clk) disable iff (srst)
		!pwmc_q[`UPB_BIT_PWM_EN] |=> boost_pwm_out == $past(pwmc_q[`UPB_BIT_POL]))
		else $error("idle level ignores polarity");

	AST_TARGET_SEL: assert property (@(posedge clk) disable iff (srst)
		s_otg_write |=> vbus_target_select == $past(pwdata[`UPB_BIT_TARGET]))
		else $error("target select not taken");

	AST_PWM_OE: assert property (@(posedge clk) disable iff (srst)
		boost_pwm_oe |-> $past(pwmc_q[`UPB_BIT_PWM_EN]))
		else $error("pwm driven while disabled");

	AST_CNT_STOP: assert property (@(posedge clk) disable iff (srst)
		!pwmc_q[`UPB_BIT_CNT_EN] [*2] |-> pwm_count == 8'h00)
		else $error("pwm counter moved while stopped");

	AST_VOLT_GATE: assert property (@(posedge clk) disable iff (srst)
		vbus_at_target && pwmc_q[`UPB_BIT_PWM_EN] |=> boost_pwm_out == $past(pwmc_q[`UPB_BIT_POL]))
		else $error("pulse above target voltage");

	AST_APB_ERR: assert property (@(posedge clk) disable iff (srst)
		access_ph && sel == upb_pkg::UPB_SEL_NONE
		|-> pready && pslverr && (pwrite || prdata == 32'h0000_0000))
		else $error("unmapped access not flagged");

	// Register bits reaching the pins, then the PWM control register contents
	AST_PWR_BIT: assert property (@(posedge clk) disable iff (srst)
		s_pwr_write |=> usb_power_on == $past(pwdata[`UPB_BIT_PWR_ON]))
		else $error("power bit not taken");

	AST_DISCHG_BIT: assert property (@(posedge clk) disable iff (srst)
		s_otg_write |=> vbus_discharge_on == $past(pwdata[`UPB_BIT_DISCHG]))
		else $error("discharge bit not taken");

	AST_VBUS_GEN_BIT: assert property (@(posedge clk) disable iff (srst)
		s_otg_write |=> vbus_gen_on == $past(pwdata[`UPB_BIT_VBUS_GEN]))
		else $error("generation enable not taken");

	AST_PWMC_WRITE: assert property (@(posedge clk) disable iff (srst)
		s_pwmc_write |=> pwmc_q == ($past(pwdata[15:0]) & `UPB_MASK_PWM_CTRL))
		else $error("pwm control bits misplaced");

	// Refused writes
	AST_DEAD_WRITE: assert property (@(posedge clk) disable iff (srst)
		s_dead_write |=> $stable(ctrl_q) && $stable(otg_q) && $stable(pwr_q)
		&& $stable(perd_q) && $stable(pwmc_q))
		else $error("ignored write changed a register");

	// Read path, then device role pull-downs
	AST_RD_CAPTURE: assert property (@(posedge clk) disable iff (srst)
		s_read_setup ##0 sel == upb_pkg::UPB_SEL_OTG_CTRL
		|=> prdata == {16'h0000, $past(otg_q)})
		else $error("read data not captured at setup");

	AST_RD_UPPER: assert property (@(posedge clk) disable iff (srst)
		access_ph && !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("upper read half not zero");

	AST_DEV_NO_PULLDOWN: assert property (@(posedge clk) disable iff (srst)
		s_ctrl_write ##0 !otg_q[`UPB_BIT_OVERRIDE] ##0 !pwdata[`UPB_BIT_HOST_EN]
		|-> ##2 !dplus_pulldown_on && !dminus_pulldown_on)
		else $error("pull-downs on in device role");
endmodule // upb_top

// ==== upb_cfg.svh ====
// Register map, field positions, reset values and rule overview for the USB pull and boost block
// Overview of operation
// - In device operation, setting the module enable bit of the USB control register engages the D+ pull-up.
// - With OTG pull override enabled, the D+ pull-up follows its own dedicated control bit instead.
// - Setting the host role enable bit engages the D+ and D- pull-downs together.
// - With OTG pull override enabled, the D+ and D- pull-downs follow one dedicated bit each.
// - The boost assist drives a PWM for an external supply, gated by voltage and current comparators.
// - Boost PWM period is bits 7:0 and duty cycle bits 15:8 of the period and duty register.
// - Boost PWM output polarity is chosen by bit 9 of the PWM control register.
// - The VBUS target voltage is chosen by bit 1 of the OTG control register.
// - The boost PWM counter runs only while its counter enable bit 8 is 1.
// - The boost PWM drives its output only while the PWM enable bit 15 is 1.
`ifndef UPB_CFG_SVH
`define UPB_CFG_SVH

// Register byte offsets
`define UPB_OFS_USB_CTRL 8'h00
`define UPB_OFS_OTG_CTRL 8'h04
`define UPB_OFS_PWR 8'h08
`define UPB_OFS_PER_DUTY 8'h0C
`define UPB_OFS_PWM_CTRL 8'h10
`define UPB_OFS_STATUS 8'h14

// Usb control fields
`define UPB_BIT_MOD_EN 0
`define UPB_BIT_HOST_EN 3
// Otg control fields
`define UPB_BIT_DISCHG 0
`define UPB_BIT_TARGET 1
`define UPB_BIT_OVERRIDE 2
`define UPB_BIT_VBUS_GEN 3
`define UPB_BIT_DM_PD 4
`define UPB_BIT_DP_PD 5
`define UPB_BIT_DP_PU 7
// Power fields
`define UPB_BIT_PWR_ON 0
// Period and duty fields
`define UPB_PER_LSB 0
`define UPB_DUTY_LSB 8
// Pwm control fields
`define UPB_BIT_CNT_EN 8
`define UPB_BIT_POL 9
`define UPB_BIT_PWM_EN 15

// Write masks and reset values
`define UPB_MASK_USB_CTRL 16'h0009
`define UPB_MASK_OTG_CTRL 16'h00BF
`define UPB_MASK_PWR 16'h0001
`define UPB_MASK_PER_DUTY 16'hFFFF
`define UPB_MASK_PWM_CTRL 16'h8300
`define UPB_RST_REG 16'h0000

`endif

// ==== upb_pkg.sv ====
// Types shared by the USB pull and boost block
package upb_pkg;
	typedef logic [15:0] upb_reg_t;
	typedef logic [31:0] upb_word_t;
	typedef enum {
		UPB_SEL_USB_CTRL,
		UPB_SEL_OTG_CTRL,
		UPB_SEL_PWR,
		UPB_SEL_PER_DUTY,
		UPB_SEL_PWM_CTRL,
		UPB_SEL_STATUS,
		UPB_SEL_NONE
	} upb_sel_e;
endpackage

// ==== upb_pull_ctrl.sv ====
// Line termination selection for D+ and D-
`timescale 1ns/100ps
`include "upb_cfg.svh"
module upb_pull_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Control bits
	input wire logic usb_module_enable,
	input wire logic host_role_enable,
	input wire logic otg_pull_override_enable,
	input wire logic dplus_pullup_ctrl,
	input wire logic dplus_pulldown_ctrl,
	input wire logic dminus_pulldown_ctrl,
	// Termination enables
	output logic dplus_pullup_on,
	output logic dplus_pulldown_on,
	output logic dminus_pulldown_on
);
	logic pu_q, pu_d, dpd_q, dpd_d, dmd_q, dmd_d;

	always_comb begin
		if (otg_pull_override_enable) begin
			pu_d = dplus_pullup_ctrl;
			dpd_d = dplus_pulldown_ctrl;
			dmd_d = dminus_pulldown_ctrl;
		end else begin
			pu_d = usb_module_enable & ~host_role_enable;
			dpd_d = host_role_enable;
			dmd_d = host_role_enable;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pu_q <= 1'b0;
			dpd_q <= 1'b0;
			dmd_q <= 1'b0;
		end else begin
			pu_q <= pu_d;
			dpd_q <= dpd_d;
			dmd_q <= dmd_d;
		end
	end

	assign dplus_pullup_on = pu_q;
	assign dplus_pulldown_on = dpd_q;
	assign dminus_pulldown_on = dmd_q;

	AST_HOST_PAIR: assert property (@(posedge clk) disable iff (srst)
		!otg_pull_override_enable ##1 !$past(otg_pull_override_enable)
		|-> dplus_pulldown_on == dminus_pulldown_on)
		else $error("host pull-downs split");
endmodule // upb_pull_ctrl

// ==== upb_boost_pwm.sv ====
// Boost assist PWM with comparator gating
`timescale 1ns/100ps
module upb_boost_pwm #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Setup
	input wire logic [W-1:0] period,
	input wire logic [W-1:0] duty,
	input wire logic boost_counter_enable,
	input wire logic boost_pwm_enable,
	input wire logic boost_pwm_polarity,
	// Comparators
	input wire logic vbus_at_target,
	input wire logic over_current,
	// Drive
	output logic pwm_out,
	output logic pwm_oe,
	output logic [W-1:0] count
);
	logic [W-1:0] cnt_q, cnt_d;
	logic out_q, out_d, oe_q, oe_d, on;

	always_comb begin
		cnt_d = '0;
		if (boost_counter_enable && cnt_q < period) begin
			cnt_d = cnt_q + W'(1);
		end
		on = boost_counter_enable & (cnt_q < duty) & ~vbus_at_target & ~over_current;
		oe_d = boost_pwm_enable;
		out_d = boost_pwm_enable ? (on ^ boost_pwm_polarity) : boost_pwm_polarity;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_q <= '0;
			out_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			out_q <= out_d;
			oe_q <= oe_d;
		end
	end

	assign pwm_out = out_q;
	assign pwm_oe = oe_q;
	assign count = cnt_q;

	AST_CNT_HOLD: assert property (@(posedge clk) disable iff (srst)
		!boost_counter_enable |=> cnt_q == '0)
		else $error("counter ran while disabled");
	AST_CUR_LIMIT: assert property (@(posedge clk) disable iff (srst)
		over_current && boost_pwm_enable |=> out_q == $past(boost_pwm_polarity))
		else $error("pulse during over current");
	AST_CNT_WRAP: assert property (@(posedge clk) disable iff (srst)
		boost_counter_enable && cnt_q >= period |=> cnt_q == '0)
		else $error("counter passed period");
endmodule // upb_boost_pwm

// ==== upb_boost_model.sv ====
// Far side model of the external boost supply and its comparators
`timescale 1ns/100ps
module upb_boost_model (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Boost drive
	input wire logic pwm_out,
	input wire logic pwm_oe,
	input wire logic pol,
	input wire logic gen_on,
	input wire logic target_sel,
	input wire logic fault,
	// Comparators
	output logic vbus_at_target,
	output logic over_current
);
	int level_q;
	// Output charges one step per active pulse cycle
	always_ff @(posedge clk) begin
		if (srst || !gen_on) begin
			level_q <= 0;
		end else if (pwm_oe && (pwm_out ^ pol) && level_q < 255) begin
			level_q <= level_q + 1;
		end
	end
	// Higher target takes more charge
	assign vbus_at_target = level_q >= (target_sel ? 50 : 30);
	assign over_current = fault;
endmodule // upb_boost_model

// ==== tb_usb_pull_and_vbus_boost_ctrl.sv ====
// Testbench for the USB pull and boost block
`timescale 1ns/100ps
`include "upb_cfg.svh"
module tb_usb_pull_and_vbus_boost_ctrl;
	logic clk, srst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic vbus_at_target, over_current, pu, dppd, dmpd, pwm_out, pwm_oe;
	logic tgt, gen, dis, pwr, pol, fault;
	logic [32:0] expq[$];
	logic [15:0] lf, u, o, pv;
	logic [7:0] ofs[5];
	logic [15:0] msk[5];
	int n_mismatch, checks, act, i, k;

	upb_top uut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.vbus_at_target(vbus_at_target), .over_current(over_current),
		.dplus_pullup_on(pu), .dplus_pulldown_on(dppd), .dminus_pulldown_on(dmpd),
		.boost_pwm_out(pwm_out), .boost_pwm_oe(pwm_oe), .vbus_target_select(tgt),
		.vbus_gen_on(gen), .vbus_discharge_on(dis), .usb_power_on(pwr));
	upb_boost_model partner (.clk(clk), .srst(srst), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
		.pol(pol), .gen_on(gen), .target_sel(tgt), .fault(fault),
		.vbus_at_target(vbus_at_target), .over_current(over_current));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// One APB transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d,
		input logic [32:0] e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {16'h0000, d};
		if (!wr) expq.push_back(e);
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (n == 16) begin
			n_mismatch++;
			print_verdict();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, a, d, 33'h0_0000_0000);
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		apb(1'b0, a, 16'h0000, {17'h0_0000, e});
	endtask

	// Count cycles with the pulse in its active level
	task automatic meas(input int n, output int a);
		a = 0;
		repeat (3) @(posedge clk);
		repeat (n) begin
			@(posedge clk);
			if (pwm_out !== pol) a++;
		end
	endtask

	// Read data checked against the oldest note
	always @(posedge clk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
			chk({pslverr, prdata}, expq.pop_front());
		end
	end

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		srst = 1'b1;
		pol = 1'b0;
		fault = 1'b0;
		lf = 16'h49e8;
		n_mismatch = 0;
		checks = 0;
		ofs = '{`UPB_OFS_USB_CTRL, `UPB_OFS_OTG_CTRL, `UPB_OFS_PWR, `UPB_OFS_PER_DUTY,
			`UPB_OFS_PWM_CTRL};
		msk = '{`UPB_MASK_USB_CTRL, `UPB_MASK_OTG_CTRL, `UPB_MASK_PWR, `UPB_MASK_PER_DUTY,
			`UPB_MASK_PWM_CTRL};
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		// Reset values and unmapped access
		for (i = 0; i < 5; i++) rd(ofs[i], 16'h0000);
		rd(`UPB_OFS_STATUS, 16'h0000);
		apb(1'b0, 8'h18, 16'h0000, 33'h1_0000_0000);
		chk({32'h0000_0000, pu}, 33'h0_0000_0000);
		$display("test reset done");
		// Pull selection, all enable combinations with and without override
		for (i = 0; i < 8; i++) begin
			lf = lfsr(lf);
			u = {12'h000, i[1], 2'b00, i[0]};
			o = (lf & 16'h00b0) | (i[2] ? 16'h0004 : 16'h0000);
			wr(`UPB_OFS_USB_CTRL, u);
			wr(`UPB_OFS_OTG_CTRL, o);
			pv = o[2] ? {13'h0000, o[4], o[5], o[7]} : {13'h0000, u[3], u[3], u[0] & ~u[3]};
			rd(`UPB_OFS_STATUS, pv);
			chk({30'h0000_0000, dmpd, dppd, pu}, {17'h0_0000, pv});
		end
		$display("test pulls done");
		// Pull-up stays on through an idle suspend stretch
		wr(`UPB_OFS_OTG_CTRL, 16'h0000);
		wr(`UPB_OFS_USB_CTRL, 16'h0001);
		repeat (50) @(posedge clk);
		chk({32'h0000_0000, pu}, 33'h0_0000_0001);
		$display("test suspend done");
		// Register masks with random data
		for (i = 0; i < 5; i++) begin
			lf = lfsr(lf);
			wr(ofs[i], lf);
			rd(ofs[i], lf & msk[i]);
		end
		$display("test registers done");
		// Boost PWM setup in documented order, both polarities and targets
		for (i = 0; i < 2; i++) begin
			pol <= i[0];
			pv = i[0] ? 16'h0200 : 16'h0000;
			wr(`UPB_OFS_PWR, 16'h0001);
			wr(`UPB_OFS_OTG_CTRL, 16'h0000);
			wr(`UPB_OFS_PER_DUTY, 16'h0309);
			rd(`UPB_OFS_PWR, 16'h0001);
			chk({31'h0000_0000, pwr, dis}, 33'h0_0000_0002);
			wr(`UPB_OFS_PWM_CTRL, pv);
			wr(`UPB_OFS_OTG_CTRL, {14'h0000, i[0], 1'b0});
			wr(`UPB_OFS_PWM_CTRL, pv | 16'h0100);
			wr(`UPB_OFS_PWM_CTRL, pv | 16'h8100);
			meas(40, act);
			chk(33'(act), 33'd12);
			chk({32'h0000_0000, pwm_oe}, 33'h0_0000_0001);
			chk({32'h0000_0000, tgt}, {32'h0000_0000, i[0]});
			fault <= 1'b1;
			meas(20, act);
			chk(33'(act), 33'd0);
			fault <= 1'b0;
			wr(`UPB_OFS_OTG_CTRL, {12'h000, 1'b1, 1'b0, i[0], 1'b0});
			@(posedge clk);
			chk({32'h0000_0000, gen}, 33'h0_0000_0001);
			for (k = 0; k < 400 && vbus_at_target !== 1'b1; k++) @(posedge clk);
			chk({32'h0000_0000, vbus_at_target}, 33'h0_0000_0001);
			meas(40, act);
			chk(33'(act), 33'd0);
			wr(`UPB_OFS_OTG_CTRL, 16'h0000);
			wr(`UPB_OFS_PWM_CTRL, pv | 16'h8000);
			meas(20, act);
			chk(33'(act), 33'd0);
			wr(`UPB_OFS_PWM_CTRL, pv | 16'h0100);
			meas(20, act);
			chk(33'(act), 33'd0);
			chk({32'h0000_0000, pwm_oe}, 33'h0_0000_0000);
		end
		$display("test boost done");
		print_verdict();
	end
endmodule // tb_usb_pull_and_vbus_boost_ctrl
